// *** pkg/flash_sector_pkg.sv ***
/*
  Shared constants for the flash sector select and status block: register
  indices and byte addresses, field positions, reset values and widths.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package flash_sector_pkg;

  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 32;
  localparam int REG_W    = 16;
  localparam int NSECT    = 12;
  localparam int NLOW     = 10;
  localparam int NEV      = 3;

  // Printed offsets are not all multiples of four: they are indices
  localparam logic [ADDR_W-1:0] IDX_SEL_LOW   = 24'h0e0004;
  localparam logic [ADDR_W-1:0] IDX_SEL_HIGH  = 24'h0e0006;
  localparam logic [ADDR_W-1:0] IDX_INT_STAT  = 24'h0e0020;
  localparam logic [ADDR_W-1:0] IDX_INT_MASK  = 24'h0e0022;
  localparam logic [ADDR_W-1:0] IDX_CTRL      = 24'h0e0024;
  localparam int                IDX_SHIFT     = 2;

  localparam logic [ADDR_W-1:0] ADDR_SEL_LOW  = IDX_SEL_LOW << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] ADDR_SEL_HIGH = IDX_SEL_HIGH << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = IDX_INT_STAT << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = IDX_INT_MASK << IDX_SHIFT;
  localparam logic [ADDR_W-1:0] ADDR_CTRL     = IDX_CTRL << IDX_SHIFT;

  // Field positions
  localparam int HIGH_S10_POS    = 0;
  localparam int HIGH_S11_POS    = 1;
  localparam int HIGH_BANK_POS   = 8;
  localparam int HIGH_LEGACY_POS = 9;
  localparam int LOW_S10_POS     = 10;
  localparam int LOW_S11_POS     = 11;
  localparam int CTRL_OPERATION_SUSPEND_POS   = 14;

  // Interrupt event positions
  localparam int EV_ERR_POS  = 0;
  localparam int EV_OPERATION_SUSPEND_POS = 1;
  localparam int EV_DONE_POS = 2;

  localparam logic [REG_W-1:0]  SEL_RESET  = 16'h0000;
  localparam logic [NEV-1:0]    EV_RESET   = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;

endpackage : flash_sector_pkg

// *** rtl/sector_status_cell.sv ***
/*
  One sector or bank status bit: software selects it, hardware reports
  into it and clears it. Assumes all inputs are on core_clk.
*/
`timescale 1ns/10ps
module sector_status_cell (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Software side
  input  wire logic swWrite,
  input  wire logic swData,
  input  wire logic swLocked,
  // Hardware side
  input  wire logic hwWrite,
  input  wire logic hwData,
  input  wire logic hwClear,
  // State
  output logic      bitQ
);

  logic bit_d;

  // Hardware report wins over clear, clear over software
  always_comb begin
    bit_d = bitQ;
    if (hwWrite) begin
      bit_d = hwData;
    end else if (hwClear) begin
      bit_d = 1'b0;
    end else if (swWrite && !swLocked) begin
      bit_d = swData;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bitQ <= 1'b0;
    end else begin
      bitQ <= bit_d;
    end
  end

endmodule : sector_status_cell

// *** rtl/flash_sector_select_status.sv ***
/*
  Sector select and erase status registers of the flash controller, with
  an APB slave, sticky event flags, a mask and one interrupt line.
  Assumes the program/erase state machine runs on core_clk and reports
  busy, operation flags, status updates and completion with a pulse.
*/
// Chosen here: the APB interface to the registers.
// How it works
// - Low register bits 9:0 pick sectors 0 to 9 for sector erase.
// - High register bits 1:0 pick sectors 10 and 11.
// - During erase, hardware writes per-sector status into the sector bits.
// - A write finishing without error clears all sector bits.
// - During erase, hardware updates the bank status at high bit 8.
// - An erase ending without error clears the bank status.
// - High bit 9 always reads the bank status.
// - Low bits 11:10 are the same storage as high bits 1:0.
// - With erase flag set, set bits mean erase errors.
// - Erase clear and suspend set means suspended; both clear means nothing.
// - Any number of sectors may be chosen before the launch.
// - A suspend control bit pauses program or erase for reads elsewhere.
`timescale 1ns/10ps
module flash_sector_select_status (
  // Clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  // APB slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [flash_sector_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [flash_sector_pkg::DATA_W-1:0]   pwdata,
  output logic      [flash_sector_pkg::DATA_W-1:0]   prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Program/erase state machine
  input  wire logic                                  fsmBusy,
  input  wire logic                                  fsmEraseFlag,
  input  wire logic                                  fsmSuspendFlag,
  input  wire logic                                  fsmStatusWrite,
  input  wire logic [flash_sector_pkg::NSECT-1:0]    fsmSectorStatus,
  input  wire logic                                  fsmBankStatus,
  input  wire logic                                  fsmDone,
  input  wire logic                                  fsmDoneErase,
  input  wire logic                                  fsmDoneError,
  // To the state machine and status users
  output logic      [flash_sector_pkg::NSECT-1:0]    sectorSelect,
  output logic                                       operationSuspend,
  output logic      [flash_sector_pkg::NSECT-1:0]    sectorEraseError,
  output logic      [flash_sector_pkg::NSECT-1:0]    sectorSuspended,
  output logic                                       bankEraseError,
  output logic                                       bankSuspended,
  // Interrupt
  output logic                                       irq
);

  import flash_sector_pkg::*;

  // Bus decode
  wire logic setupPhase;
  wire logic accessPhase;
  wire logic writeTaken;
  wire logic readTaken;
  wire logic hitLow;
  wire logic hitHigh;
  wire logic hitStat;
  wire logic hitMask;
  wire logic hitCtrl;
  wire logic hitAny;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable && pready;
  assign writeTaken  = accessPhase && pwrite && !pslverr;
  assign readTaken   = accessPhase && !pwrite && !pslverr;
  assign hitLow      = (paddr == ADDR_SEL_LOW);
  assign hitHigh     = (paddr == ADDR_SEL_HIGH);
  assign hitStat     = (paddr == ADDR_INT_STAT);
  assign hitMask     = (paddr == ADDR_INT_MASK);
  assign hitCtrl     = (paddr == ADDR_CTRL);
  assign hitAny      = hitLow || hitHigh || hitStat || hitMask || hitCtrl;

  // Sector and bank storage
  logic [NSECT-1:0] sectorQ;
  logic             bankQ;

  wire logic [NSECT-1:0] swSectWrite;
  wire logic [NSECT-1:0] swSectData;
  wire logic             hwSectWrite;
  wire logic             hwBankWrite;
  wire logic             cleanWriteEnd;
  wire logic             cleanEraseEnd;

  // Low copy of sectors 10 and 11 is the same storage as the high copy
  genvar gi;
  generate
    for (gi = 0; gi < NSECT; gi++) begin : g_sect
      if (gi < NLOW) begin : g_low
        assign swSectWrite[gi] = writeTaken && hitLow;
        assign swSectData[gi]  = pwdata[gi];
      end else begin : g_high
        assign swSectWrite[gi] = writeTaken && (hitLow || hitHigh);
        assign swSectData[gi]  = hitLow ? pwdata[gi] : pwdata[gi - NLOW];
      end
      sector_status_cell u_cell (
        .core_clk (core_clk),
        .rst      (rst),
        .swWrite  (swSectWrite[gi]),
        .swData   (swSectData[gi]),
        .swLocked (fsmBusy),
        .hwWrite  (hwSectWrite),
        .hwData   (fsmSectorStatus[gi]),
        .hwClear  (cleanWriteEnd),
        .bitQ     (sectorQ[gi])
      );
    end
  endgenerate

  // Hardware owns the bits while busy; software selection is locked out
  assign hwSectWrite   = fsmStatusWrite && fsmBusy;
  assign hwBankWrite   = fsmStatusWrite && fsmBusy;
  assign cleanWriteEnd = fsmDone && !fsmDoneError;
  assign cleanEraseEnd = fsmDone && fsmDoneErase && !fsmDoneError;

  // Bank status is never software writable
  sector_status_cell u_bank (
    .core_clk (core_clk),
    .rst      (rst),
    .swWrite  (1'b0),
    .swData   (1'b0),
    .swLocked (1'b1),
    .hwWrite  (hwBankWrite),
    .hwData   (fsmBankStatus),
    .hwClear  (cleanEraseEnd),
    .bitQ     (bankQ)
  );

  // Register read images; reserved bits read zero
  wire logic [REG_W-1:0] lowImage;
  wire logic [REG_W-1:0] highImage;

  assign lowImage = {{(REG_W - NSECT){1'b0}}, sectorQ};
  assign highImage = {{(REG_W - HIGH_LEGACY_POS - 1){1'b0}},
                      bankQ,
                      bankQ,
                      {(HIGH_BANK_POS - HIGH_S11_POS - 1){1'b0}},
                      sectorQ[LOW_S11_POS],
                      sectorQ[LOW_S10_POS]};

  // Suspend control
  logic suspend_q;
  logic suspend_d;

  // A control write wins; otherwise cleared when the operation completes
  always_comb begin
    suspend_d = suspend_q;
    if (writeTaken && hitCtrl) begin
      suspend_d = pwdata[CTRL_OPERATION_SUSPEND_POS];
    end else if (fsmDone) begin
      suspend_d = 1'b0;
    end
  end

  // Events
  wire logic [NEV-1:0] evPulse;
  logic      [NEV-1:0] evStat_q;
  logic      [NEV-1:0] evStat_d;
  logic      [NEV-1:0] evMask_q;
  logic      [NEV-1:0] evMask_d;
  wire logic           anyReported;

  assign anyReported = (|fsmSectorStatus) || fsmBankStatus;
  assign evPulse[EV_ERR_POS]  = hwSectWrite && fsmEraseFlag && anyReported;
  assign evPulse[EV_OPERATION_SUSPEND_POS] = hwSectWrite && !fsmEraseFlag && fsmSuspendFlag
                                && anyReported;
  assign evPulse[EV_DONE_POS] = cleanWriteEnd;

  // A new event beats the read that clears it
  always_comb begin
    evStat_d = evStat_q;
    if (readTaken && hitStat) begin
      evStat_d = {NEV{1'b0}};
    end
    evStat_d = evStat_d | evPulse;
  end

  always_comb begin
    evMask_d = evMask_q;
    if (writeTaken && hitMask) begin
      evMask_d = pwdata[NEV-1:0];
    end
  end

  // Read words, reserved bits zero
  wire logic [DATA_W-1:0] lowWord;
  wire logic [DATA_W-1:0] highWord;
  wire logic [DATA_W-1:0] statWord;
  wire logic [DATA_W-1:0] maskWord;
  wire logic [DATA_W-1:0] ctrlWord;
  wire logic [DATA_W-1:0] rdSel;

  assign lowWord  = {{(DATA_W - REG_W){1'b0}}, lowImage};
  assign highWord = {{(DATA_W - REG_W){1'b0}}, highImage};
  assign statWord = {{(DATA_W - NEV){1'b0}}, evStat_q};
  assign maskWord = {{(DATA_W - NEV){1'b0}}, evMask_q};
  assign ctrlWord = {{(DATA_W - CTRL_OPERATION_SUSPEND_POS - 1){1'b0}}, suspend_q, {CTRL_OPERATION_SUSPEND_POS{1'b0}}};
  // Unmapped addresses read zero
  assign rdSel    = hitLow  ? lowWord  :
                    hitHigh ? highWord :
                    hitStat ? statWord :
                    hitMask ? maskWord :
                    hitCtrl ? ctrlWord : RDATA_ZERO;

  // Status meaning depends on the operation flags
  wire logic showErr;
  wire logic showSusp;

  assign showErr  = fsmEraseFlag;
  assign showSusp = !fsmEraseFlag && fsmSuspendFlag;

  // Zero on writes keeps prdata quiet outside reads
  wire logic [DATA_W-1:0] rdNext;

  assign rdNext = (setupPhase && !pwrite) ? rdSel : RDATA_ZERO;

  // Bus answer: one wait-free access cycle after every setup cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !hitAny;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= RDATA_ZERO;
    end else begin
      prdata <= rdNext;
    end
  end

  // Control and event state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      suspend_q <= 1'b0;
      evStat_q  <= EV_RESET;
      evMask_q  <= EV_RESET;
    end else begin
      suspend_q <= suspend_d;
      evStat_q  <= evStat_d;
      evMask_q  <= evMask_d;
    end
  end

  // Status shown only under its flag pair
  wire logic [NSECT-1:0] sectErrNext;
  wire logic [NSECT-1:0] sectSuspNext;
  wire logic             irqNext;

  assign sectErrNext  = showErr ? sectorQ : {NSECT{1'b0}};
  assign sectSuspNext = showSusp ? sectorQ : {NSECT{1'b0}};
  assign irqNext      = |(evStat_q & evMask_q);

  // Registered outputs, one cycle behind the storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sectorSelect     <= {NSECT{1'b0}};
      operationSuspend <= 1'b0;
    end else begin
      sectorSelect     <= sectorQ;
      operationSuspend <= suspend_q;
    end
  end

  // Erase error view
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sectorEraseError <= {NSECT{1'b0}};
      bankEraseError   <= 1'b0;
    end else begin
      sectorEraseError <= sectErrNext;
      bankEraseError   <= showErr && bankQ;
    end
  end

  // Suspend view
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sectorSuspended <= {NSECT{1'b0}};
      bankSuspended   <= 1'b0;
    end else begin
      sectorSuspended <= sectSuspNext;
      bankSuspended   <= showSusp && bankQ;
    end
  end

  // Interrupt level, one cycle late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irqNext;
    end
  end

endmodule : flash_sector_select_status

// *** tb/flash_sector_checker.sv ***
/*
  Concurrent checks on the sector select and status block ports.
  Assumes one core_clk domain with rst active high; bound at the foot.
*/
`timescale 1ns/10ps
module flash_sector_checker (
  // Clock and reset
  input wire logic                                 core_clk,
  input wire logic                                 rst,
  // APB
  input wire logic                                 pwrite,
  input wire logic [flash_sector_pkg::ADDR_W-1:0]  paddr,
  input wire logic [flash_sector_pkg::DATA_W-1:0]  prdata,
  input wire logic                                 pready,
  // Engine side
  input wire logic                                 fsmBusy,
  input wire logic                                 fsmEraseFlag,
  input wire logic                                 fsmSuspendFlag,
  input wire logic                                 fsmStatusWrite,
  input wire logic [flash_sector_pkg::NSECT-1:0]   fsmSectorStatus,
  input wire logic                                 fsmBankStatus,
  input wire logic                                 fsmDone,
  input wire logic                                 fsmDoneErase,
  input wire logic                                 fsmDoneError,
  // Outputs
  input wire logic [flash_sector_pkg::NSECT-1:0]   sectorSelect,
  input wire logic [flash_sector_pkg::NSECT-1:0]   sectorEraseError,
  input wire logic [flash_sector_pkg::NSECT-1:0]   sectorSuspended,
  input wire logic                                 bankEraseError,
  input wire logic                                 bankSuspended
);
  import flash_sector_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_LEGACY_COPY: assert property (pready && !pwrite && paddr == ADDR_SEL_HIGH |-> prdata[9] == prdata[8])
    else $error("legacy bank copy differs");
  AST_RESV_LOW: assert property (pready && !pwrite && paddr == ADDR_SEL_LOW |-> prdata[31:12] == 20'h00000)
    else $error("reserved low bits read nonzero");
  AST_RESV_HIGH: assert property (pready && !pwrite && paddr == ADDR_SEL_HIGH |-> prdata[31:10] == 22'h000000 && prdata[7:2] == 6'h00)
    else $error("reserved high bits read nonzero");
  AST_SECTOR_LOAD: assert property (fsmStatusWrite && fsmBusy ##1 fsmEraseFlag |=> sectorEraseError == $past(fsmSectorStatus, 2))
    else $error("sector status not loaded");
  AST_BANK_LOAD: assert property (fsmStatusWrite && fsmBusy ##1 fsmEraseFlag |=> bankEraseError == $past(fsmBankStatus, 2))
    else $error("bank status not loaded");
  AST_NO_MEANING: assert property (!fsmEraseFlag && !fsmSuspendFlag |=> sectorSuspended == 12'h000 && sectorEraseError == 12'h000 && !bankSuspended && !bankEraseError)
    else $error("status shown with both flags clear");
  AST_ERASE_NOT_OPERATION_SUSPEND: assert property (fsmEraseFlag |=> sectorSuspended == 12'h000 && !bankSuspended)
    else $error("suspend shown during erase");
  AST_CLEAR_WRITE: assert property (fsmDone && !fsmDoneError && !fsmStatusWrite |=> ##1 sectorSelect == 12'h000)
    else $error("sector bits not cleared");
  AST_CLEAR_BANK: assert property (fsmDone && fsmDoneErase && !fsmDoneError && !fsmStatusWrite |=> ##1 !bankEraseError && !bankSuspended)
    else $error("bank status not cleared");
  AST_LOCK: assert property ((fsmBusy && !fsmStatusWrite && !fsmDone)[*3] |-> $stable(sectorSelect))
    else $error("sector bits changed while busy");
endmodule : flash_sector_checker

bind flash_sector_select_status flash_sector_checker u_chk (.core_clk, .rst, .pwrite, .paddr, .prdata, .pready,
  .fsmBusy, .fsmEraseFlag, .fsmSuspendFlag, .fsmStatusWrite, .fsmSectorStatus, .fsmBankStatus, .fsmDone,
  .fsmDoneErase, .fsmDoneError, .sectorSelect, .sectorEraseError, .sectorSuspended, .bankEraseError, .bankSuspended);

// *** tb/erase_fsm_model.sv ***
/*
  Behavioural program/erase engine facing the sector block.
  Assumes its tasks are called just after a core_clk edge.
*/
`timescale 1ns/10ps
module erase_fsm_model (
  // Clock
  input  wire logic                                core_clk,
  // From the block
  input  wire logic [flash_sector_pkg::NSECT-1:0]  sectorSelect,
  input  wire logic                                operationSuspend,
  // To the block
  output logic                                     fsmBusy,
  output logic                                     fsmEraseFlag,
  output logic                                     fsmSuspendFlag,
  output logic                                     fsmStatusWrite,
  output logic      [flash_sector_pkg::NSECT-1:0]  fsmSectorStatus,
  output logic                                     fsmBankStatus,
  output logic                                     fsmDone,
  output logic                                     fsmDoneErase,
  output logic                                     fsmDoneError
);
  import flash_sector_pkg::*;
  logic eraseQ;
  initial begin
    eraseQ = 1'b0;
    fsmBusy = 1'b0;
    fsmStatusWrite = 1'b0;
    fsmSectorStatus = 12'ha5a;
    fsmBankStatus = 1'b1;
    fsmDone = 1'b0;
    fsmDoneErase = 1'b1;
    fsmDoneError = 1'b1;
  end
  // Suspend drops the erase flag so status reads as suspended
  assign fsmEraseFlag   = fsmBusy & eraseQ & ~operationSuspend;
  assign fsmSuspendFlag = fsmBusy & operationSuspend;
  task automatic start(input logic er);
    @(posedge core_clk);
    fsmBusy <= 1'b1;
    eraseQ  <= er;
  endtask : start
  // Only selected sectors are reported; bus shows junk outside the pulse
  task automatic report(input logic [NSECT-1:0] st, input logic bk);
    @(posedge core_clk);
    fsmStatusWrite  <= 1'b1;
    fsmSectorStatus <= st & sectorSelect;
    fsmBankStatus   <= bk;
    @(posedge core_clk);
    fsmStatusWrite  <= 1'b0;
    fsmSectorStatus <= ~st;
    fsmBankStatus   <= ~bk;
  endtask : report
  task automatic finish(input logic err);
    @(posedge core_clk);
    fsmDone      <= 1'b1;
    fsmDoneErase <= eraseQ;
    fsmDoneError <= err;
    fsmBusy      <= 1'b0;
    @(posedge core_clk);
    fsmDone      <= 1'b0;
    fsmDoneErase <= ~eraseQ;
    fsmDoneError <= ~err;
  endtask : finish
endmodule : erase_fsm_model

// *** tb/testbench.sv ***
/*
  Self-checking bench: APB tasks and call sequences with expected values.
  Assumes the package, design, engine model and checker are compiled first.
*/
`timescale 1ns/10ps
module testbench;
  import flash_sector_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  logic              psel     = 1'b0;
  logic              penable  = 1'b0;
  logic              pwrite   = 1'b0;
  logic [ADDR_W-1:0] paddr    = 24'h000000;
  logic [DATA_W-1:0] pwdata   = 32'h00000000;
  logic [DATA_W-1:0] prdata, rdat;
  logic              pready, pslverr, rerr, irq, operationSuspend, bankEraseError, bankSuspended;
  logic              fsmBusy, fsmEraseFlag, fsmSuspendFlag, fsmStatusWrite, fsmBankStatus;
  logic              fsmDone, fsmDoneErase, fsmDoneError;
  logic [NSECT-1:0]  sectorSelect, fsmSectorStatus, sectorEraseError, sectorSuspended;
  int                badCount   = 0;
  int                checkCount = 0;
  always #25 core_clk = ~core_clk;
  flash_sector_select_status u_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fsmBusy, .fsmEraseFlag, .fsmSuspendFlag, .fsmStatusWrite, .fsmSectorStatus, .fsmBankStatus,
    .fsmDone, .fsmDoneErase, .fsmDoneError, .sectorSelect, .operationSuspend, .sectorEraseError,
    .sectorSuspended, .bankEraseError, .bankSuspended, .irq);
  erase_fsm_model u_fsm (.core_clk, .sectorSelect, .operationSuspend, .fsmBusy, .fsmEraseFlag, .fsmSuspendFlag,
    .fsmStatusWrite, .fsmSectorStatus, .fsmBankStatus, .fsmDone, .fsmDoneErase, .fsmDoneError);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Idle cycle between transfers keeps each signal to one assignment per step
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask : wr_reg
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rdat, exp);
  endtask : rd_chk
  task automatic endSim;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : endSim
  initial begin
    #200us;
    badCount++;
    endSim();
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(ADDR_SEL_LOW, 32'h00000000);
    rd_chk(ADDR_SEL_HIGH, 32'h00000000);
    wr_reg(ADDR_SEL_LOW, 32'h00000fff);
    rd_chk(ADDR_SEL_LOW, 32'h00000fff);
    rd_chk(ADDR_SEL_HIGH, 32'h00000003);
    wr_reg(ADDR_SEL_HIGH, 32'h00000302);
    rd_chk(ADDR_SEL_HIGH, 32'h00000002);
    rd_chk(ADDR_SEL_LOW, 32'h00000bff);
    wr_reg(ADDR_SEL_LOW, 32'h00000e0f);
    repeat (2) @(posedge core_clk);
    check({20'h00000, sectorSelect}, 32'h00000e0f);
    apb(1'b0, 24'h000100, 32'h00000000);
    check({31'h00000000, rerr}, 32'h00000001);
    check(rdat, 32'h00000000);
    u_fsm.start(1'b1);
    wr_reg(ADDR_SEL_LOW, 32'h00000000);
    rd_chk(ADDR_SEL_LOW, 32'h00000e0f);
    u_fsm.report(12'h4f5, 1'b1);
    rd_chk(ADDR_SEL_LOW, 32'h00000405);
    rd_chk(ADDR_SEL_HIGH, 32'h00000301);
    check({20'h00000, sectorEraseError}, 32'h00000405);
    check({31'h00000000, bankEraseError}, 32'h00000001);
    check({31'h00000000, irq}, 32'h00000000);
    wr_reg(ADDR_INT_MASK, 32'h00000001);
    repeat (2) @(posedge core_clk);
    check({31'h00000000, irq}, 32'h00000001);
    rd_chk(ADDR_INT_STAT, 32'h00000001);
    repeat (2) @(posedge core_clk);
    check({31'h00000000, irq}, 32'h00000000);
    rd_chk(ADDR_INT_STAT, 32'h00000000);
    wr_reg(ADDR_CTRL, 32'h00004000);
    repeat (3) @(posedge core_clk);
    check({31'h00000000, operationSuspend}, 32'h00000001);
    check({20'h00000, sectorSuspended}, 32'h00000405);
    check({20'h00000, sectorEraseError}, 32'h00000000);
    check({31'h00000000, bankSuspended}, 32'h00000001);
    u_fsm.report(12'h4f5, 1'b1);
    u_fsm.finish(1'b0);
    repeat (3) @(posedge core_clk);
    check({20'h00000, sectorSelect}, 32'h00000000);
    check({31'h00000000, operationSuspend}, 32'h00000000);
    rd_chk(ADDR_SEL_HIGH, 32'h00000000);
    rd_chk(ADDR_INT_STAT, 32'h00000006);
    wr_reg(ADDR_SEL_LOW, 32'h00000003);
    u_fsm.start(1'b0);
    u_fsm.report(12'h003, 1'b0);
    repeat (2) @(posedge core_clk);
    check({20'h00000, sectorEraseError | sectorSuspended}, 32'h00000000);
    u_fsm.finish(1'b1);
    rd_chk(ADDR_SEL_LOW, 32'h00000003);
    endSim();
  end
endmodule : testbench
